/* rtl/hvi_port.sv */
// High-voltage input port control: buffer gating, analog routing and AXI4-Lite registers
//
// Function
// [RULE1] Each enable bit gates its pin buffer
// [RULE2] Analog link forces buffer off in run
// [RULE3] Test bit keeps buffer on, run only
// [RULE4] Direct link always keeps buffer off
// [RULE5] Pull bit: pulldown, pullup under test run
// [RULE6] Bypass powers down converter, direct only
// [RULE7] Direct link skips divider while linked
// [RULE8] Link enable connects selected pin only
// [RULE9] Two-bit selector picks one of four pins
// [RULE10] Software waits settling plus two cycles
// [RULE11] Readback shows pin only when digital
// [RULE12] Unused bits read zero, ignore writes
`timescale 1ns/1ns
module hvi_port
  import hvi_pkg::*;
#(
  parameter int pin_count = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device mode and pins
  input wire logic stop_mode,
  input wire logic [3:0] high_voltage_input_pin,
  // Analog side controls
  output logic [3:0] input_buffer_enable,
  output logic [3:0] analog_connect,
  output logic divider_active,
  output logic direct_connect,
  output logic converter_bypass,
  output logic pullup_enable,
  output logic pulldown_enable
);

  // Selector is two bits wide, so only four pins can be served
  if (pin_count != 4)
  begin : gen_pin_check
    $error("hvi_port supports exactly four pins");
  end

  // Register storage
  logic [7:0] digital_input_enable_bits;
  logic [7:0] next_digital_input_enable_bits;
  logic [7:0] analog_ctl;
  logic [7:0] next_analog_ctl;

  // Write channel state
  logic aw_held;
  logic next_aw_held;
  logic [3:0] aw_addr;
  logic [3:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [7:0] w_data;
  logic [7:0] next_w_data;
  logic w_lane0;
  logic next_w_lane0;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;

  // Read channel state
  logic rvalid;
  logic next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;

  // Output registers
  logic [3:0] buf_en;
  logic [3:0] next_buf_en;
  logic [3:0] conn;
  logic [3:0] next_conn;
  logic div_act;
  logic next_div_act;
  logic dir_con;
  logic next_dir_con;
  logic byp;
  logic next_byp;
  logic pu;
  logic next_pu;
  logic pd;
  logic next_pd;

  // Synchronised pins and stop mode
  logic [3:0] pin_sync;
  logic stop_sync;

  hvi_sync #(
    .width(5)
  ) u_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in({stop_mode, high_voltage_input_pin}),
    .sync_out({stop_sync, pin_sync})
  );

  // Field views of the analog control register
  logic open_input_test_enable;
  logic test_pull_select;
  logic converter_bypass_bit;
  logic direct_link_select;
  logic analog_link_enable;
  logic [1:0] analog_pin_selector;

  assign open_input_test_enable = analog_ctl[hvi_bit_test];
  assign test_pull_select = analog_ctl[hvi_bit_pull];
  assign converter_bypass_bit = analog_ctl[hvi_bit_byp];
  assign direct_link_select = analog_ctl[hvi_bit_dir];
  assign analog_link_enable = analog_ctl[hvi_bit_aen];
  assign analog_pin_selector = analog_ctl[hvi_sel_lo +: 2];

  // Decode of a byte address to a mapped register, used by both channels
  function automatic logic is_mapped(input logic [3:0] addr, input logic writable);
    logic hit;
    hit = (addr == hvi_addr_dien) || (addr == hvi_addr_actl);
    if (!writable)
      hit = hit || (addr == hvi_addr_pins) || (addr == hvi_addr_mode);
    return hit;
  endfunction

  // Pin-level buffer, routing and readback logic
  logic [3:0] port_input_readback;
  logic [3:0] sel_onehot;

  always_comb
  begin
    sel_onehot = 4'h0;
    sel_onehot[analog_pin_selector] = 1'b1; // [RULE9]
    next_conn = analog_link_enable ? sel_onehot : 4'h0; // [RULE8]
    for (int i = 0; i < 4; i++)
    begin
      // Start from the plain digital enable
      next_buf_en[i] = digital_input_enable_bits[i]; // [RULE1]
      if (analog_link_enable && sel_onehot[i])
      begin
        if (stop_sync)
          next_buf_en[i] = digital_input_enable_bits[i]; // [RULE2] [RULE3]
        else
          next_buf_en[i] = open_input_test_enable; // [RULE2] [RULE3]
        if (direct_link_select)
          next_buf_en[i] = 1'b0; // [RULE4]
      end
      // Readback is one unless the pin is purely digital
      if (digital_input_enable_bits[i] && !next_conn[i])
        port_input_readback[i] = pin_sync[i]; // [RULE11]
      else
        port_input_readback[i] = 1'b1; // [RULE11]
    end
    next_div_act = analog_link_enable && !direct_link_select; // [RULE7]
    next_dir_con = analog_link_enable && direct_link_select; // [RULE7]
    next_byp = next_dir_con && converter_bypass_bit; // [RULE6]
    next_pu = analog_link_enable && test_pull_select && open_input_test_enable
              && !stop_sync; // [RULE5]
    next_pd = analog_link_enable && !next_pu; // [RULE5]
  end

  // Output registers for the analog side
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      buf_en <= 4'h0;
      conn <= 4'h0;
      div_act <= 1'b0;
      dir_con <= 1'b0;
      byp <= 1'b0;
      pu <= 1'b0;
      pd <= 1'b0;
    end
    else
    begin
      buf_en <= next_buf_en;
      conn <= next_conn;
      div_act <= next_div_act;
      dir_con <= next_dir_con;
      byp <= next_byp;
      pu <= next_pu;
      pd <= next_pd;
    end
  end

  assign input_buffer_enable = buf_en;
  assign analog_connect = conn;
  assign divider_active = div_act;
  assign direct_connect = dir_con;
  assign converter_bypass = byp;
  assign pullup_enable = pu;
  assign pulldown_enable = pd;

  // Write path: address and data taken in either order, response after both
  logic do_write;

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_digital_input_enable_bits = digital_input_enable_bits;
    next_analog_ctl = analog_ctl;
    do_write = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (next_aw_held && next_w_held && !next_bvalid)
    begin
      do_write = 1'b1;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_mapped(next_aw_addr, 1'b1) ? hvi_resp_okay : hvi_resp_slverr;
    end
    // Only byte lane 0 holds implemented bits
    if (do_write && next_w_lane0)
    begin
      if (next_aw_addr == hvi_addr_dien)
        next_digital_input_enable_bits = next_w_data & hvi_mask_dien; // [RULE12]
      else if (next_aw_addr == hvi_addr_actl)
        next_analog_ctl = next_w_data & hvi_mask_actl; // [RULE12]
    end
  end

  // A new write is only taken once the previous response has left
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
      w_held <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= hvi_resp_okay;
      digital_input_enable_bits <= hvi_rst_dien;
      analog_ctl <= hvi_rst_actl;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      digital_input_enable_bits <= next_digital_input_enable_bits;
      analog_ctl <= next_analog_ctl;
    end
  end

  // Read path: one cycle from address to data
  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = is_mapped(s_axi_araddr, 1'b0) ? hvi_resp_okay : hvi_resp_slverr;
      unique case (s_axi_araddr)
        hvi_addr_dien: next_rdata = {24'h000000, digital_input_enable_bits};
        hvi_addr_actl: next_rdata = {24'h000000, analog_ctl};
        hvi_addr_pins: next_rdata = {28'h0000000, port_input_readback}; // [RULE11]
        hvi_addr_mode: next_rdata = {31'h0, stop_sync};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= hvi_resp_okay;
    end
    else
    begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

endmodule

/* shared/hvi_pkg.sv */
// Package with register map, field positions and reset values for the input port control
package hvi_pkg;
  // Register byte addresses (chosen)
  localparam logic [3:0] hvi_addr_dien = 4'h0;
  localparam logic [3:0] hvi_addr_actl = 4'h4;
  localparam logic [3:0] hvi_addr_pins = 4'h8;
  localparam logic [3:0] hvi_addr_mode = 4'hc;
  // Control register field positions
  localparam int hvi_bit_test = 7;
  localparam int hvi_bit_pull = 6;
  localparam int hvi_bit_byp = 5;
  localparam int hvi_bit_dir = 4;
  localparam int hvi_bit_aen = 3;
  localparam int hvi_sel_lo = 0;
  // Implemented bit masks
  localparam logic [7:0] hvi_mask_dien = 8'h0f;
  localparam logic [7:0] hvi_mask_actl = 8'hfb;
  // Reset values
  localparam logic [7:0] hvi_rst_dien = 8'h00;
  localparam logic [7:0] hvi_rst_actl = 8'h00;
  // AXI responses
  localparam logic [1:0] hvi_resp_okay = 2'h0;
  localparam logic [1:0] hvi_resp_slverr = 2'h2;
endpackage

/* rtl/hvi_sync.sv */
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ns
module hvi_sync #(
  parameter int width = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Data
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] stage1;
  logic [width-1:0] stage2;

  // Only stage2 reads stage1, keeping metastability off the logic
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1 <= '0;
      stage2 <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end

  assign sync_out = stage2;
endmodule

/* verif/hvi_pin_model.sv */
// Pin-side model: drives the four high-voltage input pins
`timescale 1ns/1ns
module hvi_pin_model (
  // Levels requested by the bench
  input wire logic [3:0] level,
  // Pull controls from the port
  input wire logic [3:0] analog_connect,
  input wire logic pullup_enable,
  input wire logic pulldown_enable,
  // Pins
  output logic [3:0] high_voltage_input_pin
);
  // A linked pin is treated as open, so the active pull device sets its level
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (analog_connect[i] && (pullup_enable || pulldown_enable))
        high_voltage_input_pin[i] = pullup_enable;
      else
        high_voltage_input_pin[i] = level[i];
    end
  end
endmodule

/* verif/hvi_port_props.sv */
// Port-level assertions for the high-voltage input port control
`timescale 1ns/1ns
module hvi_port_chk
  import hvi_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // Mode and analog side
  input wire logic stop_mode,
  input wire logic [3:0] input_buffer_enable,
  input wire logic [3:0] analog_connect,
  input wire logic divider_active,
  input wire logic direct_connect,
  input wire logic converter_bypass,
  input wire logic pullup_enable,
  input wire logic pulldown_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Routing and path consistency
  chk_one_pin: assert property ($onehot0(analog_connect))
    else $error("more than one pin linked");
  chk_path_link: assert property ((divider_active || direct_connect) == (|analog_connect)
    && !(divider_active && direct_connect))
    else $error("path select wrong");
  chk_bypass_direct: assert property (converter_bypass |-> direct_connect)
    else $error("bypass without direct path");
  chk_pull_link: assert property ((pullup_enable || pulldown_enable) == (|analog_connect)
    && !(pullup_enable && pulldown_enable))
    else $error("pull device wrong");
  chk_direct_buffer: assert property (direct_connect
    |-> (input_buffer_enable & analog_connect) == 4'h0)
    else $error("buffer on in direct path");
  // Stop needs two sync stages and one output stage before it shows
  chk_stop_pull: assert property (stop_mode [*4] |=> !pullup_enable)
    else $error("pullup in stop");
  // Bus answers
  chk_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid)
    else $error("no write response");
  chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule
bind hvi_port hvi_port_chk u_chk (.clock, .rstn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .stop_mode,
  .input_buffer_enable, .analog_connect, .divider_active, .direct_connect,
  .converter_bypass, .pullup_enable, .pulldown_enable);

/* verif/tb_top.sv */
// Self-checking bench for the high-voltage input port control
`timescale 1ns/1ns
module tb_top
  import hvi_pkg::*;
;
  typedef struct packed {logic [7:0] dien; logic [7:0] actl; logic stop;
    logic [12:0] outs; logic [3:0] rb;} hvi_row_type;
  // Rows: enables, control, stop, {buffers, links, div dir byp pu pd}, readback
  hvi_row_type rows [0:9] = '{
    {8'hff, 8'h00, 1'b0, 13'h1e00, 4'h6}, {8'h05, 8'h00, 1'b0, 13'h0a00, 4'he},
    {8'h0f, 8'h0c, 1'b0, 13'h1c31, 4'h7}, {8'h0f, 8'h89, 1'b0, 13'h1e51, 4'h6},
    {8'h0f, 8'hca, 1'b0, 13'h1e92, 4'h6}, {8'h0f, 8'hfb, 1'b0, 13'h0f0e, 4'he},
    {8'h0f, 8'h2b, 1'b0, 13'h0f11, 4'he}, {8'h08, 8'hcb, 1'b1, 13'h1111, 4'hf},
    {8'h00, 8'h8b, 1'b1, 13'h0111, 4'hf}, {8'h0f, 8'h13, 1'b0, 13'h1e00, 4'h6}};
  logic clock, rstn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready, stop_mode;
  logic awready, wready, arready, div, dir, byp, pu, pd;
  logic [3:0] awaddr, araddr, wstrb, pins, buf_en, con;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  int failures = 0, cmp_count = 0, cycles = 0;
  hvi_port dut (.clock, .rstn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .stop_mode,
    .high_voltage_input_pin(pins), .input_buffer_enable(buf_en), .analog_connect(con),
    .divider_active(div), .direct_connect(dir), .converter_bypass(byp),
    .pullup_enable(pu), .pulldown_enable(pd));
  hvi_pin_model far_pins (.level(4'h6), .analog_connect(con), .pullup_enable(pu),
    .pulldown_enable(pd), .high_voltage_input_pin(pins));
  // Clock at 100 MHz
  initial
  begin
    clock = 1'b0;
    forever #5 clock = !clock;
  end
  // Hang guard, well above the expected few hundred cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      conclude();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic pa, pw, go;
    @(posedge clock);
    awaddr <= a; wdata <= {24'h0, v}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    do
    begin
      #1;
      go = bvalid;
      r = bresp;
      if (awready) pa = 1'b0;
      if (wready) pw = 1'b0;
      @(posedge clock);
      if (!pa) awvalid <= 1'b0;
      if (!pw) wvalid <= 1'b0;
    end while (!go);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    logic pa, go;
    @(posedge clock);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    pa = 1'b1;
    do
    begin
      #1;
      go = rvalid;
      d = rdata;
      r = rresp;
      if (arready) pa = 1'b0;
      @(posedge clock);
      if (!pa) arvalid <= 1'b0;
    end while (!go);
    rready <= 1'b0;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    rstn = 1'b0; stop_mode = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0;
    wstrb = 4'hf;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    foreach (rows[k])
    begin
      @(posedge clock);
      stop_mode <= rows[k].stop;
      wr(hvi_addr_dien, rows[k].dien);
      wr(hvi_addr_actl, rows[k].actl);
      repeat (6) @(posedge clock); // Settling plus sync delay
      #1;
      cmp(32'({buf_en, con, div, dir, byp, pu, pd}), 32'(rows[k].outs));
      rd(hvi_addr_dien);
      cmp(d, 32'(rows[k].dien & hvi_mask_dien));
      rd(hvi_addr_actl);
      cmp(d, 32'(rows[k].actl & hvi_mask_actl));
      rd(hvi_addr_pins);
      cmp(d, 32'(rows[k].rb));
      rd(hvi_addr_mode);
      cmp(d, 32'(rows[k].stop));
      $display("row %0d done", k);
    end
    // Write to the read-only readback place is refused and changes nothing
    wr(hvi_addr_pins, 8'hff);
    cmp(32'(r), 32'(hvi_resp_slverr));
    rd(hvi_addr_dien);
    cmp(d, 32'h0000000f);
    $display("refusal test done");
    // Unmapped read is refused and returns zero data
    rd(4'h2);
    cmp(d, 32'h0);
    cmp(32'(r), 32'(hvi_resp_slverr));
    // Lane 0 not strobed: write answered OKAY and the register keeps its value
    wstrb <= 4'he;
    wr(hvi_addr_dien, 8'h00);
    cmp(32'(r), 32'(hvi_resp_okay));
    wstrb <= 4'hf;
    rd(hvi_addr_dien);
    cmp(d, 32'h0000000f);
    cmp(32'(r), 32'(hvi_resp_okay));
    $display("strobe and unmapped test done");
    // Reset in mid-run clears outputs and registers
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    cmp(32'({buf_en, con}), 32'h0);
    @(posedge clock);
    rstn <= 1'b1;
    rd(hvi_addr_actl);
    cmp(d, 32'(hvi_rst_actl));
    rd(hvi_addr_dien);
    cmp(d, 32'(hvi_rst_dien));
    $display("reset test done");
    conclude();
  end
endmodule
